// [logic/psam_mapper.sv]
// Operation
// [RQ1] Table address is table page above the 16-bit effective address.
// [RQ2] Table page bit 7 picks configuration space, else user space.
// [RQ3] Window access: read page low 8 bits joined to EA 14..0.
// [RQ4] Read page bit 8 picks lower or upper program word.
// [RQ5] Window program address bit 23 is always zero.
// [RQ6] Window ignores EA bit 15; address bit 15 is page bit 0.
// [RQ7] Word low-table read returns program bits 15..0.
// [RQ8] Byte low-table read returns upper or lower byte per byte select.
// [RQ9] Word high-table read returns bits 23..16, upper data byte zero.
// [RQ10] Byte high-table read with byte select one returns zero.
// [RQ11] Table writes into configuration space are refused.
// [RQ12] Fetch counter advances by two per instruction word.
// [RQ13] Pages 200h-2FFh are lower words, 300h-3FFh upper words.
// [RQ14] EA at or above 8000h with page zero raises address error.
// [RQ15] Window move costs one extra cycle, others two, outside repeat.
// [RQ16] In repeat, edge iterations cost two extra cycles, others none.
// [RQ17] Writes through the window never touch program memory.
// [RQ18] EA bit 15 with page bit 9 clear forms 24-bit data address.
// [RQ19] EA bit 15 clear is a plain data access, pages unused.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module psam_mapper (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire psam_pkg::psam_req_t req,
  output logic req_ready,
  output psam_pkg::psam_mem_t mem,
  input wire logic [23:0] pmem_rdata,
  input wire logic [15:0] dmem_rdata,
  output psam_pkg::psam_resp_t resp,
  input wire logic fetch_adv,
  output logic [23:0] fetch_addr
);
  import psam_pkg::*;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_CAPT = 2'b11,
    ST_HOLD = 2'b10
  } psam_state_t;
  typedef struct packed {
    psam_space_t sp;
    logic [23:0] addr;
    logic [1:0] extra;
  } psam_dec_t;
  // Address formation for one access against the live page registers
  function automatic psam_dec_t decode(psam_req_t r, logic [7:0] tp,
                                       logic [9:0] rp, logic [9:0] wp);
    psam_dec_t d;
    logic [9:0] pg;
    d = '{sp: SP_DATA, addr: {8'h00, r.ea}, extra: XTRA_NONE}; // RQ19
    pg = r.wr ? wp : rp;
    if (r.kind != K_DATA) begin
      d.sp = SP_TBL;
      d.addr = {tp, r.ea}; // RQ1
    end else if (r.ea[EA_WIN_BIT]) begin
      if (pg == 10'h000) begin
        d.sp = SP_ERR; // RQ14
      end else if (pg[PG_PGM_BIT]) begin
        // Bit 15 comes from the page, never the EA; bit 23 stays low
        d.sp = SP_WIN;
        d.addr = {1'b0, pg[7:0], r.ea[14:0]}; // RQ3 RQ5 RQ6
        if (r.in_rep) begin
          d.extra = r.rep_edge ? XTRA_REP_EDGE : XTRA_NONE; // RQ16
        end else begin
          d.extra = r.is_move ? XTRA_MOVE : XTRA_OTHER; // RQ15
        end
      end else begin
        d.sp = SP_EXT;
        d.addr = {pg[8:0], r.ea[14:0]}; // RQ18
      end
    end
    return d;
  endfunction
  // Byte lane steering shared by table and window reads
  function automatic logic [15:0] steer(logic [15:0] w, logic bm, logic bs);
    logic [15:0] s;
    s = w;
    if (bm) begin
      s = {8'h00, bs ? w[15:8] : w[7:0]}; // RQ8 RQ10
    end
    return s;
  endfunction
  logic [7:0] tpag_r;
  logic [9:0] rpag_r;
  logic [9:0] wpag_r;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] mask_r;
  logic [NUM_EV-1:0] ev_set;
  logic [7:0] bus_addr_r;
  logic bus_wr_r;
  logic irq_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic bus_take;
  psam_state_t state_r;
  psam_req_t req_r;
  psam_dec_t dec_r;
  psam_dec_t dec_now;
  logic [7:0] tpag_s;
  logic [9:0] rpag_s;
  psam_mem_t mem_r;
  psam_resp_t resp_r;
  logic [1:0] cnt_r;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic [22:0] pc_r;
  logic refuse_now;
  logic req_ready_r;
  assign bus_take = hsel && htrans[1] && hready;
  assign dec_now = decode(req, tpag_r, rpag_r, wpag_r);
  // Bus read mux; unmapped words read as zero
  always_comb begin
    case (haddr[7:0])
      OFF_TBL_PAGE: rd_mux = {24'h00_0000, tpag_r};
      OFF_RD_PAGE: rd_mux = {22'h00_0000, rpag_r};
      OFF_WR_PAGE: rd_mux = {22'h00_0000, wpag_r};
      OFF_STATUS: rd_mux = {28'h000_0000, stat_r};
      OFF_MASK: rd_mux = {28'h000_0000, mask_r};
      OFF_INFO: rd_mux = {6'h00, state_r, dec_r.addr};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Address phase capture; data is ready in the following cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bus_addr_r <= 8'h00;
      bus_wr_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
      bus_wr_r <= bus_take && hwrite;
      if (bus_take) begin
        bus_addr_r <= haddr[7:0];
        hrdata_r <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end
  // Page and mask registers, written in the data phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tpag_r <= RST_TBL_PAGE;
      rpag_r <= RST_RD_PAGE;
      wpag_r <= RST_WR_PAGE;
      mask_r <= RST_EVENTS;
    end else if (bus_wr_r) begin
      case (bus_addr_r)
        OFF_TBL_PAGE: tpag_r <= hwdata[7:0];
        OFF_RD_PAGE: rpag_r <= hwdata[9:0];
        OFF_WR_PAGE: wpag_r <= hwdata[9:0];
        OFF_MASK: mask_r <= hwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end
  // Sticky events; a new event beats a write-one-to-clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stat_r <= RST_EVENTS;
    end else if (bus_wr_r && bus_addr_r == OFF_STATUS) begin
      stat_r <= (stat_r & ~hwdata[NUM_EV-1:0]) | ev_set;
    end else begin
      stat_r <= stat_r | ev_set;
    end
  end
  // Level interrupt from a flip-flop; folds in this cycle's events
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((stat_r | ev_set) & mask_r);
    end
  end
  // Refusals: config-space table writes and window writes
  always_comb begin
    refuse_now = 1'b0;
    if (req_r.wr) begin
      refuse_now = (dec_r.sp == SP_WIN) || // RQ17
                   (dec_r.sp == SP_TBL && dec_r.addr[23]); // RQ11
    end
    ev_set = '0;
    if (state_r == ST_ISSUE) begin
      ev_set[EV_TRAP] = dec_r.sp == SP_ERR;
      ev_set[EV_CFG_WR] = req_r.wr && dec_r.sp == SP_TBL && dec_r.addr[23];
      ev_set[EV_WIN_WR] = req_r.wr && dec_r.sp == SP_WIN;
      ev_set[EV_WIN_RD] = !req_r.wr && dec_r.sp == SP_WIN;
    end
  end
  // Lane steering of returned program and data words
  always_comb begin
    hold_nxt = steer(dmem_rdata, req_r.byte_mode, req_r.byte_sel);
    if (dec_r.sp == SP_WIN) begin
      // Upper-word pages give the high byte with a zero phantom byte
      hold_nxt = steer(rpag_s[PG_UPPER_BIT] ? {8'h00, pmem_rdata[23:16]}
                       : pmem_rdata[15:0], req_r.byte_mode,
                       req_r.byte_sel); // RQ4 RQ13
    end else if (dec_r.sp == SP_TBL) begin
      if (req_r.kind == K_TBL_HI) begin
        hold_nxt = steer({8'h00, pmem_rdata[23:16]}, req_r.byte_mode,
                         req_r.byte_sel); // RQ9
      end else begin
        hold_nxt = steer(pmem_rdata[15:0], req_r.byte_mode,
                         req_r.byte_sel); // RQ7
      end
    end
  end

  // Access sequencer: issue, capture, optional extra wait cycles
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      dec_r <= '{sp: SP_DATA, addr: 24'h00_0000, extra: XTRA_NONE};
      tpag_s <= RST_TBL_PAGE;
      rpag_s <= RST_RD_PAGE;
      cnt_r <= 2'd0;
      hold_r <= 16'h0000;
      resp_r <= '0;
      req_ready_r <= 1'b1;
    end else begin
      resp_r.done <= 1'b0;
      // Ready rises with the edge that returns the sequencer to idle
      req_ready_r <= (state_r == ST_IDLE) ? !req.valid : 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req.valid) begin
            req_r <= req;
            dec_r <= dec_now;
            tpag_s <= tpag_r;
            rpag_s <= rpag_r;
            state_r <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (dec_r.sp == SP_ERR || refuse_now || req_r.wr) begin
            // Traps and refusals finish without memory read data
            resp_r <= '{done: 1'b1, trap: dec_r.sp == SP_ERR,
                        refused: refuse_now, rdata: 16'h0000}; // RQ14
            state_r <= ST_IDLE;
            req_ready_r <= 1'b1;
          end else begin
            state_r <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          hold_r <= hold_nxt;
          cnt_r <= dec_r.extra;
          if (dec_r.extra == XTRA_NONE) begin
            resp_r <= '{done: 1'b1, trap: 1'b0, refused: 1'b0,
                        rdata: hold_nxt};
            state_r <= ST_IDLE;
            req_ready_r <= 1'b1;
          end else begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r - 2'd1;
          if (cnt_r == 2'd1) begin
            resp_r <= '{done: 1'b1, trap: 1'b0, refused: 1'b0,
                        rdata: hold_r}; // RQ15 RQ16
            state_r <= ST_IDLE;
            req_ready_r <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // Memory strobes: one-cycle pulse while the sequencer issues
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_r <= '0;
    end else begin
      mem_r.pread <= 1'b0;
      mem_r.pwrite <= 1'b0;
      mem_r.dread <= 1'b0;
      mem_r.dwrite <= 1'b0;
      if (state_r == ST_IDLE && req.valid) begin
        mem_r.paddr <= dec_now.addr;
        mem_r.daddr <= dec_now.addr;
        mem_r.wdata <= req.wdata;
        mem_r.pw_high <= req.kind == K_TBL_HI;
        if (dec_now.sp == SP_TBL) begin
          mem_r.pread <= !req.wr;
          mem_r.pwrite <= req.wr && !dec_now.addr[TBL_CFG_BIT + 16]; // RQ2 RQ11
        end else if (dec_now.sp == SP_WIN) begin
          mem_r.pread <= !req.wr; // RQ17
        end else if (dec_now.sp != SP_ERR) begin
          mem_r.dread <= !req.wr;
          mem_r.dwrite <= req.wr;
        end
      end
    end
  end
  // Instruction fetch counter, word aligned with data addresses
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pc_r <= RST_PC;
    end else if (fetch_adv) begin
      pc_r <= pc_r + PC_STEP; // RQ12
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign irq = irq_r;
  assign req_ready = req_ready_r;
  assign mem = mem_r;
  assign resp = resp_r;
  assign fetch_addr = {1'b0, pc_r};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_take_win_mv;
    state_r == ST_IDLE && req.valid && dec_now.sp == SP_WIN && !req.wr;
  endsequence
  sequence s_quiet;
    !resp_r.done [*3];
  endsequence
  property p_tbl_addr;
    mem_r.pread && dec_r.sp == SP_TBL |-> mem_r.paddr == {tpag_s, req_r.ea};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table addr"); // RQ1
  property p_cfg_wr;
    mem_r.pwrite |-> !mem_r.paddr[23] && tpag_s[TBL_CFG_BIT] == 1'b0;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write"); // RQ2 RQ11
  property p_win_addr;
    mem_r.pread && dec_r.sp == SP_WIN |->
      mem_r.paddr == {1'b0, rpag_s[7:0], req_r.ea[14:0]} && !mem_r.paddr[23];
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window addr"); // RQ3 RQ5 RQ6
  property p_win_word;
    state_r == ST_CAPT && dec_r.sp == SP_WIN && !req_r.byte_mode |=>
      hold_r == (rpag_s[8] ? {8'h00, $past(pmem_rdata[23:16])}
                 : $past(pmem_rdata[15:0]));
  endproperty
  a_win_word: assert property (p_win_word) else $error("window word"); // RQ4 RQ13
  property p_hi_zero;
    resp_r.done && req_r.kind == K_TBL_HI |-> resp_r.rdata[15:8] == 8'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("phantom byte"); // RQ9 RQ10
  property p_lo_byte;
    state_r == ST_CAPT && req_r.kind == K_TBL_LO && req_r.byte_mode |=>
      hold_r == {8'h00, req_r.byte_sel ? $past(pmem_rdata[15:8])
                 : $past(pmem_rdata[7:0])};
  endproperty
  a_lo_byte: assert property (p_lo_byte) else $error("low byte"); // RQ8
  property p_pc;
    fetch_adv |=> fetch_addr == $past(fetch_addr) + 24'd2;
  endproperty
  a_pc: assert property (p_pc) else $error("fetch step"); // RQ12
  property p_trap;
    state_r == ST_IDLE && req.valid && dec_now.sp == SP_ERR |->
      ##2 resp_r.done && resp_r.trap && stat_r[EV_TRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("trap"); // RQ14
  property p_move_time;
    s_take_win_mv ##0 (!req.in_rep && req.is_move) |->
      ##1 s_quiet ##1 resp_r.done;
  endproperty
  a_move_time: assert property (p_move_time) else $error("move time"); // RQ15
  property p_rep_time;
    s_take_win_mv ##0 (req.in_rep && !req.rep_edge) |-> ##3 resp_r.done;
  endproperty
  a_rep_time: assert property (p_rep_time) else $error("repeat time"); // RQ16
  property p_no_win_wr;
    dec_r.sp == SP_WIN |-> !mem_r.pwrite && !mem_r.dwrite;
  endproperty
  a_no_win_wr: assert property (p_no_win_wr) else $error("window write"); // RQ17
  property p_ext_addr;
    mem_r.dread && dec_r.sp == SP_EXT |->
      mem_r.daddr == {rpag_s[8:0], req_r.ea[14:0]};
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("ext addr"); // RQ18
  property p_plain;
    mem_r.dread && !req_r.ea[15] |-> mem_r.daddr == {8'h00, req_r.ea};
  endproperty
  a_plain: assert property (p_plain) else $error("plain addr"); // RQ19
endmodule // psam_mapper
`default_nettype wire

// [logic/psam_pkg.sv]
`default_nettype none
package psam_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_TBL_PAGE = 8'h00;
  localparam logic [7:0] OFF_RD_PAGE = 8'h04;
  localparam logic [7:0] OFF_WR_PAGE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_INFO = 8'h14;
  // Reset values
  localparam logic [7:0] RST_TBL_PAGE = 8'h00;
  localparam logic [9:0] RST_RD_PAGE = 10'h001;
  localparam logic [9:0] RST_WR_PAGE = 10'h001;
  localparam logic [3:0] RST_EVENTS = 4'h0;
  localparam logic [22:0] RST_PC = 23'h00_0000;
  // Field positions
  localparam int TBL_CFG_BIT = 7;
  localparam int PG_PGM_BIT = 9;
  localparam int PG_UPPER_BIT = 8;
  localparam int EA_WIN_BIT = 15;
  localparam int EV_TRAP = 0;
  localparam int EV_CFG_WR = 1;
  localparam int EV_WIN_WR = 2;
  localparam int EV_WIN_RD = 3;
  localparam int NUM_EV = 4;
  // Extra cycles of window reads
  localparam logic [1:0] XTRA_MOVE = 2'd1;
  localparam logic [1:0] XTRA_OTHER = 2'd2;
  localparam logic [1:0] XTRA_REP_EDGE = 2'd2;
  localparam logic [1:0] XTRA_NONE = 2'd0;
  localparam logic [22:0] PC_STEP = 23'd2;

  typedef enum logic [1:0] {
    K_DATA = 2'd0,
    K_TBL_LO = 2'd1,
    K_TBL_HI = 2'd2
  } psam_kind_t;

  typedef enum logic [2:0] {
    SP_DATA = 3'd0,
    SP_EXT = 3'd1,
    SP_WIN = 3'd2,
    SP_TBL = 3'd3,
    SP_ERR = 3'd4
  } psam_space_t;

  // Request from the core; rep_edge marks first/last/interrupt iterations
  typedef struct packed {
    logic valid;
    psam_kind_t kind;
    logic [15:0] ea;
    logic wr;
    logic byte_mode;
    logic byte_sel;
    logic is_move;
    logic in_rep;
    logic rep_edge;
    logic [15:0] wdata;
  } psam_req_t;

  // Strobes toward program and data memories
  typedef struct packed {
    logic [23:0] paddr;
    logic pread;
    logic pwrite;
    logic pw_high;
    logic [23:0] daddr;
    logic dread;
    logic dwrite;
    logic [15:0] wdata;
  } psam_mem_t;

  typedef struct packed {
    logic done;
    logic trap;
    logic refused;
    logic [15:0] rdata;
  } psam_resp_t;
endpackage
`default_nettype wire

// [dv/psam_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module psam_mem_model (
  input wire logic clock,
  input wire logic resetn,
  input wire psam_pkg::psam_mem_t mem,
  output logic [23:0] pmem_rdata,
  output logic [15:0] dmem_rdata
);
  import psam_pkg::*;
  // Program word follows the strobe by one cycle; idle bus toggles so stale data never looks valid
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pmem_rdata <= 24'h00_0000;
    end else if (mem.pread) begin
      pmem_rdata <= mem.paddr ^ 24'hA5_C396;
    end else begin
      pmem_rdata <= ~pmem_rdata;
    end
  end
  // Data word is a pattern of the full 24-bit address, so a wrong page bit shows
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dmem_rdata <= 16'h0000;
    end else if (mem.dread) begin
      dmem_rdata <= mem.daddr[15:0] ^ mem.daddr[23:8];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
  end
endmodule // psam_mem_model
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import psam_pkg::*;
  logic clock, resetn, hsel, hwrite, irq, hreadyout, hresp, req_ready, fetch_adv;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] pmem_rdata, fetch_addr, f, pa;
  logic [15:0] dmem_rdata;
  psam_req_t req;
  psam_mem_t mem, ms;
  psam_resp_t resp, rs;
  int error_cnt, checks, n, strobes, pwr, s0, w0, i;
  logic [7:0] offs [6] = '{OFF_TBL_PAGE, OFF_RD_PAGE, OFF_WR_PAGE, OFF_STATUS, OFF_MASK, 8'h40};
  logic [31:0] rstv [6] = '{RST_TBL_PAGE, RST_RD_PAGE, RST_WR_PAGE, RST_EVENTS, RST_EVENTS, 0};
  psam_kind_t tk [6] = '{K_TBL_LO, K_TBL_LO, K_TBL_LO, K_TBL_HI, K_TBL_HI, K_TBL_HI};
  logic [5:0] tf [6] = '{6'h00, 6'h10, 6'h18, 6'h00, 6'h10, 6'h18};
  logic [15:0] tm [6] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'h00FF};
  logic [15:0] te [6];
  logic [9:0] pg [5] = '{10'h200, 10'h2FF, 10'h300, 10'h3FF, 10'h2AB};
  logic [5:0] cf [5] = '{6'h04, 6'h00, 6'h03, 6'h02, 6'h07};
  int cn [5] = '{4, 5, 5, 3, 5};

  psam_mapper dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .req(req),
    .req_ready(req_ready), .mem(mem), .pmem_rdata(pmem_rdata), .dmem_rdata(dmem_rdata),
    .resp(resp), .fetch_adv(fetch_adv), .fetch_addr(fetch_addr));
  psam_mem_model pm (.clock(clock), .resetn(resetn), .mem(mem), .pmem_rdata(pmem_rdata),
    .dmem_rdata(dmem_rdata));

  // Free-running core clock, 4 ns period
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // Record the last memory strobe so each request can be judged after done
  always @(posedge clock) begin
    if (mem.pread | mem.pwrite | mem.dread | mem.dwrite) begin
      strobes <= strobes + 1;
      ms <= mem;
      if (mem.pwrite) begin
        pwr <= pwr + 1;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single-word transfer; every wait is on hready, never a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  // Core request held until accepted; n counts edges from acceptance to done
  task automatic rq(input psam_kind_t k, input logic [15:0] ea, input logic [5:0] fl);
    psam_req_t r;
    r.valid = 1'b1;
    r.kind = k;
    r.ea = ea;
    {r.wr, r.byte_mode, r.byte_sel, r.is_move, r.in_rep, r.rep_edge} = fl;
    r.wdata = 16'hBEEF;
    @(posedge clock);
    s0 = strobes;
    w0 = pwr;
    req <= r;
    do @(posedge clock); while (req_ready !== 1'b1);
    req <= '0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (resp.done !== 1'b1 && n < 40);
    chk(resp.done, 1'b1);
    rs = resp;
    s0 = strobes - s0;
    w0 = pwr - w0;
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {resetn, hsel, hwrite, fetch_adv, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    req = '0;
    {error_cnt, checks, strobes, pwr} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      ahb(1'b0, offs[i], 32'h0);
      chk(rd, rstv[i]);
      chk(hresp, 1'b0);
    end
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, OFF_TBL_PAGE, 32'hFFFF_FF12);
    ahb(1'b0, OFF_TBL_PAGE, 32'h0);
    chk(rd, 32'h12);
    // Table reads: every lane and mode against one program word
    f = 24'h12_3456 ^ 24'hA5_C396;
    te = '{f[15:0], f[7:0], f[15:8], f[23:16], f[23:16], 16'h0000};
    for (i = 0; i < 6; i++) begin
      rq(tk[i], 16'h3456, tf[i]);
      chk(rs.rdata & tm[i], te[i]);
      chk(ms.paddr, 24'h12_3456);
      chk(n, 3);
    end
    // Configuration space: read allowed, write refused without a strobe
    ahb(1'b1, OFF_TBL_PAGE, 32'h85);
    rq(K_TBL_LO, 16'h0010, 6'h00);
    chk(ms.paddr, 24'h85_0010);
    chk(rs.rdata, 16'h0010 ^ 16'hC396);
    rq(K_TBL_LO, 16'h0010, 6'h20);
    chk({rs.refused, w0[7:0], n[3:0]}, {1'b1, 8'h00, 4'd2});
    ahb(1'b1, OFF_TBL_PAGE, 32'h05);
    rq(K_TBL_HI, 16'h0020, 6'h20);
    chk({rs.refused, w0[5:0], ms.pw_high, ms.paddr}, {1'b0, 6'h01, 1'b1, 24'h05_0020});
    chk(ms.wdata, 16'hBEEF);
    // Window reads over page boundaries, lower and upper words
    for (i = 0; i < 5; i++) begin
      ahb(1'b1, OFF_RD_PAGE, {22'h0, pg[i]});
      rq(K_DATA, 16'h8123, 6'h00);
      pa = {1'b0, pg[i][7:0], 15'h0123};
      f = pa ^ 24'hA5_C396;
      chk(ms.paddr, pa);
      chk(rs.rdata, pg[i][8] ? {8'h00, f[23:16]} : f[15:0]);
      chk(s0, 1);
    end
    // Extra cycles of window reads in and out of repeat loops
    for (i = 0; i < 5; i++) begin
      rq(K_DATA, 16'hC000, cf[i]);
      chk(n, cn[i]);
    end
    // Window write is refused and program memory is left alone
    ahb(1'b1, OFF_WR_PAGE, 32'h201);
    rq(K_DATA, 16'h8040, 6'h20);
    chk({rs.refused, w0[7:0]}, {1'b1, 8'h00});
    // Extended data space address
    ahb(1'b1, OFF_RD_PAGE, 32'h155);
    rq(K_DATA, 16'h8ABC, 6'h00);
    chk(ms.daddr, 24'hAA_8ABC);
    chk(rs.rdata, 16'h8ABC ^ 16'hAA8A);
    // Extended-space writes above 8000h go out through the write page as a data strobe
    ahb(1'b1, OFF_WR_PAGE, 32'h155);
    rq(K_DATA, 16'h8ABC, 6'h20);
    chk({rs.refused, ms.dwrite, ms.daddr, n[3:0]}, {2'b01, 24'hAA_8ABC, 4'd2});
    // Page zero above 8000h traps with no strobe
    ahb(1'b1, OFF_RD_PAGE, 32'h0);
    rq(K_DATA, 16'h8000, 6'h00);
    chk({rs.trap, s0[7:0], n[3:0]}, {1'b1, 8'h00, 4'd2});
    // Low data space ignores the page register
    ahb(1'b1, OFF_RD_PAGE, 32'h3FF);
    rq(K_DATA, 16'h1234, 6'h00);
    chk({rs.trap, ms.dread, ms.pread, ms.daddr}, {3'b010, 24'h00_1234});
    chk(rs.rdata, 16'h1234 ^ 16'h0012);
    // Sticky events, mask and level interrupt
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'hF);
    chk(irq, 1'b0);
    ahb(1'b1, OFF_MASK, 32'h2);
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    ahb(1'b1, OFF_STATUS, 32'h2);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'hD);
    // Three back-to-back fetch steps
    @(posedge clock);
    fetch_adv <= 1'b1;
    repeat (3) @(posedge clock);
    fetch_adv <= 1'b0;
    repeat (2) @(posedge clock);
    chk(fetch_addr, 24'd6);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
